// >>> rtl/temp_monitor_consts.vh
// Register offsets, field positions, reset values and timing figures of the temperature monitor control block.
`ifndef TEMP_MONITOR_CONSTS_VH
`define TEMP_MONITOR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------------------
`define PTR_FLAG_STATUS      8'h02
`define PTR_CONFIG_READ      8'h03
`define PTR_RATE_READ        8'h04
`define PTR_CONFIG_WRITE     8'h09
`define PTR_RATE_WRITE       8'h0A
`define PTR_SINGLE_TRIGGER   8'h0F
`define PTR_CRIT_HYST        8'h21

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define POINTER_RESET        8'h00
`define CONFIG_RESET         8'h00
`define RATE_RESET           4'h8
`define CRIT_HYST_RESET      8'h0A

// ----------------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------------
`define CFG_IRQ_MASK         7
`define CFG_SHUTDOWN         6
`define CFG_PIN_FUNCTION     5
`define CFG_RANGE            2
`define CFG_WRITABLE         8'hE4

// ----------------------------------------------------------------------------
// Flag byte fields
// ----------------------------------------------------------------------------
`define FLG_BUSY             7
`define FLG_LOCAL_OVER       6
`define FLG_LOCAL_UNDER      5
`define FLG_REMOTE_OVER      4
`define FLG_REMOTE_UNDER     3
`define FLG_REMOTE_OPEN      2
`define FLG_REMOTE_CRIT      1
`define FLG_LOCAL_CRIT       0

// ----------------------------------------------------------------------------
// Conversion pacing
// ----------------------------------------------------------------------------
`define RATE_CODE_FASTEST    4'h9
`define CLOCK_KHZ            20000
`define SLOWEST_PERIOD_MS    16000
`define SLOWEST_PERIOD_CYC   (`SLOWEST_PERIOD_MS * `CLOCK_KHZ)
`define CONVERSION_CYC       1000

`endif

// >>> rtl/temp_monitor_status_config.v
// Flag byte, configuration, conversion pacing and comparator outputs of a dual-channel temperature monitor.
`timescale 1ns/100ps
`include "temp_monitor_consts.vh"

module temp_monitor_status_config #(
    parameter SLOWEST_PERIOD = `SLOWEST_PERIOD_CYC,
    parameter CONV_TIME      = `CONVERSION_CYC
) (
    input  wire       clock,
    input  wire       resetn,
    input  wire       pointerWrite,
    input  wire [7:0] pointerData,
    input  wire       dataWrite,
    input  wire [7:0] writeData,
    input  wire       dataRead,
    input  wire       addressRead,
    output reg  [7:0] readData,
    input  wire [7:0] localTemp,
    input  wire [7:0] remoteTemp,
    input  wire [7:0] localHighLimit,
    input  wire [7:0] localLowLimit,
    input  wire [7:0] remoteHighLimit,
    input  wire [7:0] remoteLowLimit,
    input  wire [7:0] localCritLimit,
    input  wire [7:0] remoteCritLimit,
    input  wire       remoteOpen,
    output reg        convBusy,
    output reg        extendedRange,
    output reg        critOutN,
    output reg        sharedPinN
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // True once the temperature has fallen to the limit minus hysteresis.
    // Done in nine bits so a high temperature plus hysteresis never wraps into a false release.
    // The hysteresis is added to the temperature rather than taken from the
    // limit, which keeps the arithmetic unsigned and free of a borrow.
    // A limit below the hysteresis therefore never releases, which is the
    // safe side for an overtemperature output.
    function released;
        input [7:0] temp;
        input [7:0] limit;
        input [7:0] hyst;
        begin
            released = ({1'b0, temp} + {1'b0, hyst}) <= {1'b0, limit};
        end
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    // Sequencer states are one-hot: waiting, converting and shut down.
    // Bit 1 is the converting state and doubles as the busy indication.
    localparam [2:0] ST_WAIT = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_SHUT = 3'b100;

    // The count is wide enough for the slowest period at the default clock;
    // a simulation may shrink both timing figures through the parameters.
    // Only the low nibble of the rate is stored, as the upper bits have
    // no meaning and always read back as zero.
    reg  [7:0]  pointer_reg;
    reg  [7:0]  config_reg;
    reg  [3:0]  rate_reg;
    reg  [7:0]  hyst_reg;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [31:0] count_reg;
    reg  [31:0] count_next;
    reg         singleShot_reg;
    reg         singleShot_next;
    reg  [4:0]  cause_reg;
    reg  [6:0]  flags_reg;
    reg  [6:0]  flags_next;
    reg         irqLatch_reg;
    reg  [7:0]  readData_next;

    // Decoded controls. The read and trigger decodes use the pointer as it
    // stood before this cycle's command, as the host expects.
    wire        alertMode   = ~config_reg[`CFG_PIN_FUNCTION];
    wire        shutdownReq = config_reg[`CFG_SHUTDOWN];
    wire        convDone    = state_reg[1] && (count_reg == CONV_TIME - 1);
    wire        flagRead    = dataRead && (pointer_reg == `PTR_FLAG_STATUS);
    wire        trigger     = dataWrite && (pointer_reg == `PTR_SINGLE_TRIGGER);
    // Pacing: the period halves with each rate step up to code 9, and the conversion
    // time is carved out of it so that only the idle time varies.
    // A period shorter than a conversion still leaves one idle cycle.
    wire [3:0]  rateCode    = (rate_reg > `RATE_CODE_FASTEST) ? `RATE_CODE_FASTEST : rate_reg;
    wire [31:0] period      = SLOWEST_PERIOD >> rateCode;
    wire [31:0] idleTime    = (period > CONV_TIME) ? period - CONV_TIME : 32'h00000001;

    // Fresh causes judged against this conversion's results.
    // These compare unsigned codes, so limits and results must use the
    // same result format for the comparison to mean anything.
    wire        lOver  = localTemp > localHighLimit;
    wire        lUnder = localTemp < localLowLimit;
    wire        rOver  = remoteTemp > remoteHighLimit;
    wire        rUnder = remoteTemp < remoteLowLimit;

    // ------------------------------------------------------------------------
    // Pointer and writable registers
    // ------------------------------------------------------------------------

    // Reserved configuration bits are forced to zero on the way in, so a
    // careless host cannot make them read back as ones.
    // The flag byte, the one-shot address and unmapped pointers fall into
    // the default branch, which leaves every register untouched.
    // Only a pointer write reloads the pointer; data writes land where it points.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pointer_reg <= `POINTER_RESET;
            config_reg  <= `CONFIG_RESET;
            rate_reg    <= `RATE_RESET;
            hyst_reg    <= `CRIT_HYST_RESET;
        end else begin
            if (pointerWrite) begin
                pointer_reg <= pointerData;
            end
            if (dataWrite) begin
                case (pointer_reg)
                    `PTR_CONFIG_WRITE: config_reg <= writeData & `CFG_WRITABLE;
                    `PTR_RATE_WRITE:   rate_reg   <= writeData[3:0];
                    `PTR_CRIT_HYST:    hyst_reg   <= writeData;
                    default:           config_reg <= config_reg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------------

    // Shutdown is honoured at the end of a conversion, never in its middle,
    // so a result is never left half updated.
    // A one-shot request is remembered until its own conversion completes
    // and sends the sequencer back to shutdown.
    // The conversion itself always takes CONV_TIME; only the wait varies.
    always @* begin
        state_next      = state_reg;
        count_next      = count_reg + 32'h00000001;
        singleShot_next = singleShot_reg;
        case (state_reg)
            ST_CONV: begin
                if (convDone) begin
                    count_next = 32'h00000000;
                    if (shutdownReq || singleShot_reg) begin
                        state_next      = ST_SHUT;
                        singleShot_next = 1'b0;
                    end else begin
                        state_next = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (shutdownReq) begin
                    state_next = ST_SHUT;
                    count_next = 32'h00000000;
                end else if (count_reg >= idleTime - 1) begin
                    state_next = ST_CONV;
                    count_next = 32'h00000000;
                end
            end
            ST_SHUT: begin
                count_next = 32'h00000000;
                if (!shutdownReq) begin
                    state_next = ST_CONV;
                end else if (trigger) begin
                    state_next      = ST_CONV;
                    singleShot_next = 1'b1;
                end
            end
            default: begin
                state_next = ST_SHUT;
                count_next = 32'h00000000;
            end
        endcase
    end

    // Reset enters the converting state, so the first results appear one
    // conversion time after reset is released.
    // A trigger while running is not seen outside ST_SHUT, so the schedule holds.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg      <= ST_CONV;
            count_reg      <= 32'h00000000;
            singleShot_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            count_reg      <= count_next;
            singleShot_reg <= singleShot_next;
        end
    end

    // ------------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------------

    // Bit 6 local over, 5 local under, 4 remote over, 3 remote under,
    // 2 remote open, 1 remote critical, 0 local critical; bit 7 is busy.
    // In comparator mode the low flags follow the latest result only, since
    // they drive no pin and latching them would only confuse the host.
    // Latched flags set at a conversion's end and clear on a flag read only
    // once their cause is gone; a set in the read's cycle wins over the clear.
    always @* begin
        flags_next = flags_reg;
        if (flagRead) begin
            if (alertMode) begin
                flags_next[6] = flags_reg[6] & cause_reg[4];
                flags_next[5] = flags_reg[5] & cause_reg[3];
                flags_next[4] = flags_reg[4] & cause_reg[2];
                flags_next[3] = flags_reg[3] & cause_reg[1];
            end
            flags_next[2] = flags_reg[2] & cause_reg[0];
        end
        if (convDone) begin
            if (alertMode) begin
                flags_next[6] = flags_next[6] | lOver;
                flags_next[5] = flags_next[5] | lUnder;
                flags_next[4] = flags_next[4] | rOver;
                flags_next[3] = flags_next[3] | rUnder;
            end else begin
                // Comparator mode: over flags use hysteresis, lows follow plainly.
                flags_next[6] = lOver | (flags_reg[6] & ~released(localTemp, localHighLimit, hyst_reg));
                flags_next[4] = rOver | (flags_reg[4] & ~released(remoteTemp, remoteHighLimit, hyst_reg));
                flags_next[5] = lUnder;
                flags_next[3] = rUnder;
            end
            flags_next[2] = flags_next[2] | remoteOpen;
            flags_next[1] = (remoteTemp > remoteCritLimit) |
                            (flags_reg[1] & ~released(remoteTemp, remoteCritLimit, hyst_reg));
            flags_next[0] = (localTemp > localCritLimit) |
                            (flags_reg[0] & ~released(localTemp, localCritLimit, hyst_reg));
        end
    end

    // A read between conversions is judged against these stored causes,
    // not against inputs that may already move towards the next result.
    // Causes are kept from the latest conversion so a read can judge them.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= 7'h00;
            cause_reg <= 5'h00;
        end else begin
            flags_reg <= flags_next;
            if (convDone) begin
                cause_reg <= {lOver, lUnder, rOver, rUnder, remoteOpen};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt latch
    // ------------------------------------------------------------------------

    // The latch is held clear in comparator mode, so switching back starts
    // from a clean pin that any of flags 6 to 2 still set re-arms at once.
    // A pending flag always wins over an address read in the same cycle.
    // In interrupt mode only the address read releases the latch, and only when everything is quiet.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irqLatch_reg <= 1'b0;
        end else if (!alertMode) begin
            irqLatch_reg <= 1'b0;
        end else if (|flags_reg[6:2]) begin
            irqLatch_reg <= 1'b1;
        end else if (addressRead && (cause_reg == 5'h00)) begin
            irqLatch_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------

    // The hysteresis register is readable too, so the host can verify it.
    // Answering zero avoids handing out stale data for a wrong pointer.
    // Read mux; unmapped pointers answer zero.
    always @* begin
        case (pointer_reg)
            `PTR_FLAG_STATUS: readData_next = {state_reg[1], flags_reg};
            `PTR_CONFIG_READ: readData_next = config_reg;
            `PTR_RATE_READ:   readData_next = {4'h0, rate_reg};
            `PTR_CRIT_HYST:   readData_next = hyst_reg;
            default:          readData_next = 8'h00;
        endcase
    end

    // Every output comes straight from a flip-flop, so the pins see the
    // flags one cycle after they change; in interrupt mode the shared pin
    // sees them two cycles after, through the latch.
    // The busy output matches the busy bit of a read made in the same cycle.
    // The mask only gates the pin; the latch keeps running, so unmasking
    // shows at once an interrupt that is still pending.
    // The critical output ignores the pin function entirely.
    // Outputs lag their sources by one clock, which keeps them glitch free.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readData      <= 8'h00;
            convBusy      <= 1'b0;
            extendedRange <= 1'b0;
            critOutN      <= 1'b1;
            sharedPinN    <= 1'b1;
        end else begin
            readData      <= readData_next;
            convBusy      <= state_reg[1];
            extendedRange <= config_reg[`CFG_RANGE];
            critOutN      <= ~(flags_reg[1] | flags_reg[0]);
            if (alertMode) begin
                sharedPinN <= ~(irqLatch_reg & ~config_reg[`CFG_IRQ_MASK]);
            end else begin
                sharedPinN <= ~(flags_reg[6] | flags_reg[4]);
            end
        end
    end

endmodule // temp_monitor_status_config

// >>> bench/temp_monitor_props.sv
// Port checker for the temperature monitor control block.
`timescale 1ns/100ps
module temp_monitor_props (
    input wire       clock,
    input wire       resetn,
    input wire       pointerWrite,
    input wire [7:0] pointerData,
    input wire       dataWrite,
    input wire [7:0] writeData,
    input wire       dataRead,
    input wire       addressRead,
    input wire [7:0] readData,
    input wire [7:0] localTemp,
    input wire [7:0] remoteTemp,
    input wire [7:0] localHighLimit,
    input wire [7:0] localLowLimit,
    input wire [7:0] remoteHighLimit,
    input wire [7:0] remoteLowLimit,
    input wire [7:0] localCritLimit,
    input wire [7:0] remoteCritLimit,
    input wire       remoteOpen,
    input wire       convBusy,
    input wire       extendedRange,
    input wire       critOutN,
    input wire       sharedPinN
);
    reg [7:0] ptr_reg;
    reg [7:0] cfg_reg;
    reg [3:0] rate_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------------
    // A data write in the same cycle as a pointer load goes to the old pointer.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ptr_reg <= 8'h00;
            cfg_reg <= 8'h00;
            rate_reg <= 4'h8;
        end else begin
            if (pointerWrite) ptr_reg <= pointerData;
            if (dataWrite && ptr_reg == 8'h09) cfg_reg <= writeData & 8'hE4;
            if (dataWrite && ptr_reg == 8'h0A) rate_reg <= writeData[3:0];
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    AST_RST_IDLE: assert property ($rose(resetn) |-> critOutN && sharedPinN) else $error("outputs active at reset");
    AST_BUSY_LEN: assert property ($rose(convBusy) |-> convBusy[*7] ##[1:2] !convBusy)
        else $error("conversion length wrong");
    AST_BUSY_BIT: assert property ($past(ptr_reg) == 8'h02 |-> readData[7] == convBusy)
        else $error("busy bit disagrees");
    AST_CFG_READ: assert property ($past(ptr_reg) == 8'h03 |-> readData == $past(cfg_reg))
        else $error("config readback wrong");
    AST_RATE_READ: assert property ($past(ptr_reg) == 8'h04 |-> readData == {4'h0, $past(rate_reg)})
        else $error("rate readback wrong");
    AST_RANGE: assert property (cfg_reg[2] == $past(cfg_reg[2]) |-> extendedRange == cfg_reg[2])
        else $error("range output wrong");
    AST_CRIT_SET: assert property ($fell(critOutN) |-> localTemp > localCritLimit || remoteTemp > remoteCritLimit)
        else $error("critical output without cause");
    AST_CRIT_CLR: assert property ($rose(critOutN) |-> localTemp <= localCritLimit && remoteTemp <= remoteCritLimit
        && ({1'b0, localTemp} + 9'h00A <= localCritLimit || {1'b0, remoteTemp} + 9'h00A <= remoteCritLimit))
        else $error("critical release outside hysteresis");
    AST_CMP_SET: assert property (cfg_reg[5] && $past(cfg_reg[5], 3) && $fell(sharedPinN)
        |-> localTemp > localHighLimit || remoteTemp > remoteHighLimit) else $error("comparator pin without cause");
    AST_MASK: assert property (!cfg_reg[5] && cfg_reg[7] && !$past(cfg_reg[5], 2) && $past(cfg_reg[7], 2)
        |-> sharedPinN) else $error("masked pin driven");
    cover property ($fell(sharedPinN));
    cover property ($fell(critOutN));
    cover property ($rose(convBusy));
endmodule // temp_monitor_props

bind temp_monitor_status_config temp_monitor_props i_props (.*);

// >>> bench/smbus_host_model.sv
// Host controller model issuing register accesses to the monitor block.
`timescale 1ns/100ps
module smbus_host_model (
    input  wire       clock,
    input  wire [7:0] readData,
    output reg        pointerWrite,
    output reg  [7:0] pointerData,
    output reg        dataWrite,
    output reg  [7:0] writeData,
    output reg        dataRead,
    output reg        addressRead
);
    // Idle bus at time zero.
    initial begin
        pointerWrite = 1'b0;
        pointerData = 8'h00;
        dataWrite = 1'b0;
        writeData = 8'h00;
        dataRead = 1'b0;
        addressRead = 1'b0;
    end
    // Every register read or write loads the pointer; released data shows the inverse so stale bytes are never reused.
    task writeReg(input [7:0] p, input [7:0] d);
        begin
            @(posedge clock);
            pointerWrite <= 1'b1;
            pointerData <= p;
            @(posedge clock);
            pointerWrite <= 1'b0;
            pointerData <= ~p;
            dataWrite <= 1'b1;
            writeData <= d;
            @(posedge clock);
            dataWrite <= 1'b0;
            writeData <= ~d;
        end
    endtask
    // Read data is taken at the edge that also takes the read pulse.
    task readReg(input [7:0] p, output [7:0] d);
        begin
            @(posedge clock);
            pointerWrite <= 1'b1;
            pointerData <= p;
            @(posedge clock);
            pointerWrite <= 1'b0;
            pointerData <= ~p;
            @(posedge clock);
            dataRead <= 1'b1;
            @(posedge clock);
            d = readData;
            dataRead <= 1'b0;
        end
    endtask
    // Address read that services the interrupt.
    task serviceIrq;
        begin
            @(posedge clock);
            addressRead <= 1'b1;
            @(posedge clock);
            addressRead <= 1'b0;
        end
    endtask
endmodule // smbus_host_model

// >>> bench/temp_monitor_status_config_tb.sv
// Self-checking testbench of the temperature monitor control block.
`timescale 1ns/100ps
module temp_monitor_status_config_tb;
    reg        clock, resetn, remoteOpen;
    reg  [7:0] localTemp, remoteTemp, localHighLimit, localLowLimit;
    reg  [7:0] remoteHighLimit, remoteLowLimit, localCritLimit, remoteCritLimit;
    wire [7:0] readData, pointerData, writeData;
    wire       pointerWrite, dataWrite, dataRead, addressRead;
    wire       convBusy, extendedRange, critOutN, sharedPinN;
    int        error_cnt, check_count, lat, irq, critL, critR, cL, n, i;
    time       t0;
    reg  [7:0] d;
    reg  [7:0] cmpTemp [0:3];
    reg        cmpPin [0:3];

    temp_monitor_status_config #(.SLOWEST_PERIOD(20480), .CONV_TIME(8)) i_dut (.*);
    smbus_host_model i_host (.*);

    // ------------------------------------------------------------------
    // Helpers and reference model
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Hang guard, reckoned well above the few thousand cycles the tests need.
    initial begin
        #2000000;
        error_cnt++;
        test_done;
    end
    task test_done;
        begin
            $display("checks %0d errors %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count++;
            if (got !== exp) begin
                error_cnt++;
                $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    task rd(input [7:0] p, input [7:0] e);
        begin
            i_host.readReg(p, d);
            chk(d, e);
        end
    endtask
    function automatic int cause();
        cause = (localTemp > localHighLimit) * 64 + (localTemp < localLowLimit) * 32
              + (remoteTemp > remoteHighLimit) * 16 + (remoteTemp < remoteLowLimit) * 8 + remoteOpen * 4;
    endfunction
    // Comparator with the default ten-count hysteresis.
    function automatic int hy(int p, int t, int lim);
        hy = t > lim ? 1 : (t + 10 <= lim ? 0 : p);
    endfunction
    // New inputs land early in a conversion so that its end samples them.
    task conv(input [7:0] l, input [7:0] r, input o);
        begin
            @(posedge convBusy);
            @(posedge clock);
            localTemp <= l;
            remoteTemp <= r;
            remoteOpen <= o;
            @(negedge convBusy);
            repeat (3) @(posedge clock);
            lat = lat | cause();
            critL = hy(critL, l, localCritLimit);
            critR = hy(critR, r, remoteCritLimit);
            cL = hy(cL, l, localHighLimit);
            irq = irq | (lat != 0);
        end
    endtask
    // Interrupt-mode step: flags, read clearing, address read release, pins.
    task step(input [7:0] l, input [7:0] r, input o, input m);
        begin
            conv(l, r, o);
            rd(8'h02, lat | critR * 2 | critL);
            lat = lat & cause();
            chk(sharedPinN, !(irq && !m));
            i_host.serviceIrq;
            if (lat == 0 && cause() == 0) irq = 0;
            repeat (3) @(posedge clock);
            chk(sharedPinN, !(irq && !m));
            chk(critOutN, !(critL || critR));
        end
    endtask
    task doReset;
        begin
            resetn <= 1'b0;
            repeat (2) @(posedge clock);
            resetn <= 1'b1;
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {resetn, remoteOpen} = 2'b00;
        {localTemp, remoteTemp} = 16'h4040;
        {localHighLimit, localLowLimit, remoteHighLimit, remoteLowLimit} = 32'h60207010;
        {localCritLimit, remoteCritLimit} = 16'h8090;
        n = $urandom(9251);
        doReset;
        i_host.writeReg(8'h02, 8'hFF);
        i_host.writeReg(8'h03, 8'hE4);
        i_host.writeReg(8'h04, 8'h03);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h08);
        for (i = 0; i < 6; i++) begin
            d = $urandom & 8'hA4;
            i_host.writeReg(8'h09, d);
            n = d;
            rd(8'h03, n);
            chk(extendedRange, n[2]);
        end
        i_host.writeReg(8'h09, 8'h00);
        for (i = 0; i < 12; i++) step($urandom, $urandom, $urandom_range(0, 3) == 0, 0);
        i_host.writeReg(8'h09, 8'h80);
        step(8'hF0, 8'h40, 0, 1);
        i_host.writeReg(8'h09, 8'h00);
        repeat (3) @(posedge clock);
        chk(sharedPinN, 0);
        step(8'h40, 8'h40, 0, 0);
        // Comparator pin: trip, hold within hysteresis, release, ignore low.
        {cmpTemp[0], cmpTemp[1], cmpTemp[2], cmpTemp[3]} = 32'h615B5610;
        {cmpPin[0], cmpPin[1], cmpPin[2], cmpPin[3]} = 4'b0011;
        i_host.writeReg(8'h09, 8'h20);
        cL = 0;
        for (i = 0; i < 4; i++) begin
            conv(cmpTemp[i], 8'h40, 0);
            chk(sharedPinN, cmpPin[i]);
        end
        i_host.writeReg(8'h09, 8'hA0);
        conv(8'h61, 8'h40, 0);
        chk(sharedPinN, 0);
        i_host.writeReg(8'h09, 8'h00);
        for (i = 5; i < 16; i++) begin
            i_host.writeReg(8'h0A, i);
            rd(8'h04, i);
            @(posedge convBusy);
            t0 = $time;
            @(negedge convBusy);
            chk(($time - t0) / 50, 8);
            @(posedge convBusy);
            chk(($time - t0) / 50, 20480 >> (i > 9 ? 9 : i));
        end
        @(negedge convBusy);
        t0 = $time;
        i_host.writeReg(8'h0F, 8'h5A);
        @(posedge convBusy);
        chk(($time - t0) / 50, 32);
        i_host.writeReg(8'h09, 8'h40);
        repeat (100) @(posedge clock);
        n = 0;
        repeat (300) @(posedge clock) n += convBusy;
        chk(n, 0);
        i_host.writeReg(8'h0F, 8'hC3);
        n = 0;
        repeat (100) @(posedge clock) n += convBusy;
        chk(n, 8);
        i_host.writeReg(8'h09, 8'h00);
        n = 0;
        repeat (100) @(posedge clock) n += convBusy;
        chk(n >= 16, 1);
        i_host.writeReg(8'h09, 8'hA4);
        doReset;
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h08);
        test_done;
    end
endmodule // temp_monitor_status_config_tb
